// ### parallel_output_and_scene_switch.sv
// Parallel I/O port: result output modes, scene switching, AXI4-Lite regs
//
// How it works
// - Handshake mode: each result word waits for a transfer request.
// - Busy stays high for the whole measurement.
// - Sync mode: after delay-count triggers, held result goes out next.
// - Sync pipeline advances once per trigger; one item per measurement.
// - Run output high in run mode, low in adjust mode.
// - Ready low during a switch and whenever busy is high.
// - Busy high for the duration of a scene or group switch.
// - Scene switch: number on low five inputs, select a high, b low.
// - Group switch: number on low five inputs, selects a and b high.
// - A command starts on the rising edge of the command trigger.
// - Busy of a switch is lengthened by a programmable extra time.
// - One measurement per rising edge of the measure trigger, only in run mode while idle.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module parallel_output_and_scene_switch
    import pio_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic step_in,
    input wire logic transfer_request_in,
    input wire logic [4:0] command_number_inputs,
    input wire logic command_select_a,
    input wire logic command_select_b,
    input wire logic command_trigger_in,
    output logic run_out,
    output logic ready_out,
    output logic busy_out,
    output logic [15:0] data_out,
    output logic gate_out
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MEASURE,
        ST_SWITCH
    } state_t;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic is_result(input logic [7:0] a);
        return a[7:4] == ADDR_RESULT_BASE[7:4] && a[1:0] == 2'h0;
    endfunction

    // Pin synchronisation
    logic [PIN_W-1:0] pin_lvl;
    logic [PIN_W-1:0] pin_rise;

    pin_sync #(.W(PIN_W)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in({step_in, transfer_request_in, command_trigger_in,
                 command_select_b, command_select_a, command_number_inputs}),
        .level_out(pin_lvl),
        .rise_out(pin_rise)
    );

    // Registers
    ctrl_t ctrl_q;
    timing_t timing_q;
    logic [15:0] result_q [RESULT_WORDS];
    logic [4:0] scene_q;
    logic [4:0] group_q;
    logic [7:0] switch_cnt_q;

    // AXI state
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic aw_have_q, w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    // Core state
    state_t state_q, state_d;
    logic [8:0] ms_left_q, ms_left_d;
    logic [31:0] div_q;
    logic tick;
    logic [15:0] hold_q [RESULT_WORDS];
    logic [2:0] hold_cnt_q;
    logic [1:0] hold_idx_q;
    logic [15:0] pipe_q [PIPE_DEPTH];
    logic [4:0] pipe_fill_q;
    logic run_q, ready_q, busy_q, gate_q;
    logic [15:0] data_q;

    logic aw_take, w_take, wr_fire, ar_take;
    logic start_meas, cmd_rise, cmd_scene, cmd_group, meas_done;
    logic busy_d;

    assign aw_take = s_axi_awvalid && awready_q;
    assign w_take = s_axi_wvalid && wready_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign ar_take = s_axi_arvalid && arready_q;

    // Write address and data are taken independently, then applied
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            awready_q <= wr_fire || !(aw_have_q || aw_take);
            wready_q <= wr_fire || !(w_have_q || w_take);
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (aw_addr_q == ADDR_CTRL ||
                            aw_addr_q == ADDR_TIMING ||
                            aw_addr_q == ADDR_STATUS ||
                            aw_addr_q == ADDR_SCENE ||
                            is_result(aw_addr_q)) ? RESP_OKAY : RESP_DECERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Software-written registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RESET;
            timing_q <= TIMING_RESET;
            for (int i = 0; i < RESULT_WORDS; i++) begin
                result_q[i] <= RESULT_RESET;
            end
        end else if (wr_fire) begin
            if (aw_addr_q == ADDR_CTRL) begin
                ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
                ctrl_q.rsvd <= '0;
            end
            if (aw_addr_q == ADDR_TIMING) begin
                timing_q <= merge(timing_q, w_data_q, w_strb_q);
                timing_q.rsvd <= '0;
            end
            if (is_result(aw_addr_q)) begin
                result_q[aw_addr_q[3:2]] <= 16'(merge({16'h0000,
                    result_q[aw_addr_q[3:2]]}, w_data_q, w_strb_q));
            end
        end
    end

    // Read channel
    logic [31:0] rd_word;
    logic [1:0] rd_resp;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_resp = RESP_OKAY;
        if (s_axi_araddr == ADDR_CTRL) begin
            rd_word = ctrl_q;
        end else if (s_axi_araddr == ADDR_TIMING) begin
            rd_word = timing_q;
        end else if (s_axi_araddr == ADDR_STATUS) begin
            rd_word = {20'h00000, pipe_fill_q, hold_cnt_q, gate_q,
                       busy_q, ready_q, run_q};
        end else if (s_axi_araddr == ADDR_SCENE) begin
            rd_word = {8'h00, switch_cnt_q, 3'h0, group_q, 3'h0, scene_q};
        end else if (is_result(s_axi_araddr)) begin
            rd_word = {16'h0000, result_q[s_axi_araddr[3:2]]};
        end else begin
            rd_resp = RESP_DECERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_resp;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // Millisecond tick, restarted whenever a timed phase starts
    assign tick = div_q == 32'(TICK_CYC - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn || state_q == ST_IDLE || tick) begin
            div_q <= 32'h0000_0000;
        end else begin
            div_q <= div_q + 32'h0000_0001;
        end
    end

    // Command decode; measurement trigger wins over a command edge
    assign start_meas = pin_rise[PIN_STEP] && ctrl_q.run &&
                        state_q == ST_IDLE;
    assign cmd_rise = pin_rise[PIN_TRIG] && ctrl_q.run &&
                      state_q == ST_IDLE && !start_meas;
    assign cmd_scene = cmd_rise && pin_lvl[PIN_SEL_A] &&
                       !pin_lvl[PIN_SEL_B];
    assign cmd_group = cmd_rise && pin_lvl[PIN_SEL_A] &&
                       pin_lvl[PIN_SEL_B];
    assign meas_done = state_q == ST_MEASURE && tick && ms_left_q <= 9'h001;

    always_comb begin
        state_d = state_q;
        ms_left_d = ms_left_q;
        case (state_q)
            ST_IDLE: begin
                if (start_meas) begin
                    state_d = ST_MEASURE;
                    ms_left_d = (timing_q.meas_ms == 8'h00) ? 9'h001 :
                                {1'b0, timing_q.meas_ms};
                end else if (cmd_scene || cmd_group) begin
                    state_d = ST_SWITCH;
                    ms_left_d = 9'(SWITCH_BASE_MS) +
                                {1'b0, timing_q.add_ms};
                end
            end
            ST_MEASURE, ST_SWITCH: begin
                if (tick) begin
                    if (ms_left_q <= 9'h001) begin
                        state_d = ST_IDLE;
                    end else begin
                        ms_left_d = ms_left_q - 9'h001;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    assign busy_d = state_d != ST_IDLE;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            ms_left_q <= 9'h000;
        end else begin
            state_q <= state_d;
            ms_left_q <= ms_left_d;
        end
    end

    // Status pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= 1'b0;
            busy_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            run_q <= ctrl_q.run;
            busy_q <= busy_d;
            ready_q <= ctrl_q.run && !busy_d;
        end
    end

    // Scene and group numbers taken as plain binary
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scene_q <= 5'h00;
            group_q <= 5'h00;
            switch_cnt_q <= 8'h00;
        end else begin
            if (cmd_scene) begin
                scene_q <= pin_lvl[PIN_NUM_LSB +: 5];
            end
            if (cmd_group) begin
                group_q <= pin_lvl[PIN_NUM_LSB +: 5];
                scene_q <= 5'h00;
            end
            if (cmd_scene || cmd_group) begin
                switch_cnt_q <= switch_cnt_q + 8'h01;
            end
        end
    end

    // Handshake holding words, released one per transfer request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_cnt_q <= 3'h0;
            hold_idx_q <= 2'h0;
            for (int i = 0; i < RESULT_WORDS; i++) begin
                hold_q[i] <= RESULT_RESET;
            end
        end else if (meas_done && ctrl_q.mode == MODE_HANDSHAKE) begin
            hold_q <= result_q;
            hold_cnt_q <= {1'b0, ctrl_q.nwords_m1} + 3'h1;
            hold_idx_q <= 2'h0;
        end else if (pin_rise[PIN_REQ] && hold_cnt_q != 3'h0 &&
                     ctrl_q.mode == MODE_HANDSHAKE) begin
            hold_cnt_q <= hold_cnt_q - 3'h1;
            hold_idx_q <= hold_idx_q + 2'h1;
        end
    end

    // Synchronisation pipeline, one item pushed per finished measurement
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pipe_fill_q <= 5'h00;
            for (int i = 0; i < PIPE_DEPTH; i++) begin
                pipe_q[i] <= RESULT_RESET;
            end
        end else if (ctrl_q.mode != MODE_SYNC) begin
            pipe_fill_q <= 5'h00;
        end else if (meas_done) begin
            pipe_q[0] <= result_q[0];
            for (int i = 1; i < PIPE_DEPTH; i++) begin
                pipe_q[i] <= pipe_q[i-1];
            end
            if (pipe_fill_q != 5'(PIPE_DEPTH)) begin
                pipe_fill_q <= pipe_fill_q + 5'h01;
            end
        end
    end

    // Result output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= 16'h0000;
            gate_q <= 1'b0;
        end else begin
            case (ctrl_q.mode)
                MODE_HANDSHAKE: begin
                    // Word shown whenever the hold counter moves on
                    if (pin_rise[PIN_REQ] && hold_cnt_q != 3'h0 &&
                        !meas_done) begin
                        data_q <= hold_q[hold_idx_q];
                        gate_q <= 1'b1;
                    end else if (start_meas) begin
                        gate_q <= 1'b0;
                    end
                end
                MODE_SYNC: begin
                    if (start_meas) begin
                        if (pipe_fill_q > {1'b0, ctrl_q.delay}) begin
                            data_q <= pipe_q[ctrl_q.delay];
                            gate_q <= 1'b1;
                        end else begin
                            gate_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    if (start_meas) begin
                        gate_q <= 1'b0;
                    end else if (meas_done) begin
                        data_q <= result_q[0];
                        gate_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign run_out = run_q;
    assign ready_out = ready_q;
    assign busy_out = busy_q;
    assign data_out = data_q;
    assign gate_out = gate_q;
endmodule
`default_nettype wire

// ### pio_pkg.sv
// Shared constants, register map and types for the parallel I/O port
package pio_pkg;

    // Clock and time base
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_TIME_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;

    // Fixed part of a scene or group switch, in ms, before the extra time
    localparam int SWITCH_BASE_MS = 1;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TIMING = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_SCENE = 8'h0c;
    localparam logic [7:0] ADDR_RESULT_BASE = 8'h10;

    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] TIMING_RESET = 32'h0000_0001;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Positions of the synchronised pins
    localparam int PIN_W = 10;
    localparam int PIN_NUM_LSB = 0;
    localparam int PIN_SEL_A = 5;
    localparam int PIN_SEL_B = 6;
    localparam int PIN_TRIG = 7;
    localparam int PIN_REQ = 8;
    localparam int PIN_STEP = 9;

    // Storage sizes
    localparam int RESULT_WORDS = 4;
    localparam int PIPE_DEPTH = 16;

    typedef enum logic [1:0] {
        MODE_NONE,
        MODE_HANDSHAKE,
        MODE_SYNC
    } out_mode_t;

    // Control register: run[0], mode[2:1], delay[6:3], words-1[8:7]
    typedef struct packed {
        logic [22:0] rsvd;
        logic [1:0] nwords_m1;
        logic [3:0] delay;
        out_mode_t mode;
        logic run;
    } ctrl_t;

    // Timing register: measure time ms[7:0], extra switch time ms[15:8]
    typedef struct packed {
        logic [15:0] rsvd;
        logic [7:0] add_ms;
        logic [7:0] meas_ms;
    } timing_t;

endpackage

// ### pin_sync.sv
// Two-stage synchroniser with rising-edge detect for external pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out,
    output logic [W-1:0] rise_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign rise_out = sync_q & ~prev_q;
endmodule
`default_nettype wire

// ### pio_port_monitor.sv
// Checker of status outputs and register bus answers
`timescale 1ns/1ps
`default_nettype none
module pio_chk
    import pio_pkg::*;
#(
    parameter int TICK_CYC = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic step_in,
    input wire logic command_trigger_in,
    input wire logic command_select_a,
    input wire logic run_out,
    input wire logic ready_out,
    input wire logic busy_out,
    input wire logic gate_out
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_READY_BUSY: assert property (busy_out |-> !ready_out)
        else $error("ready high while busy");
    AST_BUSY_RUN: assert property ($rose(busy_out) |-> $past(run_out))
        else $error("busy started outside run mode");
    AST_BUSY_MIN: assert property ($rose(busy_out) |-> busy_out[*8])
        else $error("busy too short");
    AST_STEP_BUSY: assert property (
        $rose(step_in) && ready_out |-> ##[2:6] busy_out)
        else $error("step did not start a measurement");
    AST_TRIG_BUSY: assert property (
        $rose(command_trigger_in) && command_select_a && ready_out
        |-> ##[2:6] busy_out)
        else $error("command trigger did not start a switch");
    AST_READ_RESP: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_READ_DONE: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    AST_WRITE_DONE: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");

    cover property ($rose(busy_out) && command_trigger_in);
    cover property ($rose(gate_out));
    cover property (s_axi_bvalid && s_axi_bresp == RESP_DECERR);
endmodule

bind parallel_output_and_scene_switch pio_chk #(.TICK_CYC(TICK_CYC)) chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .step_in(step_in), .command_trigger_in(command_trigger_in),
    .command_select_a(command_select_a), .run_out(run_out),
    .ready_out(ready_out), .busy_out(busy_out), .gate_out(gate_out)
);
`default_nettype wire

// ### plc_model.sv
// Line controller model driving the measure, request and command pins
`timescale 1ns/1ps
`default_nettype none
module plc_model #(
    parameter int TICK_CYC = 10
) (
    input wire logic aclk,
    input wire logic busy_out,
    output logic step_in,
    output logic transfer_request_in,
    output logic [4:0] command_number_inputs,
    output logic command_select_a,
    output logic command_select_b,
    output logic command_trigger_in
);
    logic seen_busy = 1'b0;
    int busy_len = 0;

    initial begin
        step_in = 1'b0;
        transfer_request_in = 1'b0;
        command_number_inputs = 5'h00;
        command_select_a = 1'b0;
        command_select_b = 1'b0;
        command_trigger_in = 1'b0;
    end

    task automatic idle_wait();
        for (int n = 0; n < 9000; n++) begin
            if (!busy_out) return;
            @(posedge aclk);
        end
        tb_parallel_output_and_scene_switch.hang();
    endtask

    task automatic see_rise();
        seen_busy = 1'b0;
        for (int n = 0; n < 12 && !seen_busy; n++) begin
            @(posedge aclk);
            seen_busy = busy_out;
        end
        busy_len = int'(seen_busy);
    endtask

    task automatic count_len();
        for (int n = 0; n < 9000; n++) begin
            @(posedge aclk);
            if (!busy_out) return;
            busy_len++;
        end
        tb_parallel_output_and_scene_switch.hang();
    endtask

    // Measurements only ever come from the step pin
    task automatic measure();
        idle_wait();
        step_in <= 1'b1;
        see_rise();
        step_in <= 1'b0;
        count_len();
    endtask

    task automatic request();
        idle_wait();
        transfer_request_in <= 1'b1;
        repeat (6) @(posedge aclk);
        transfer_request_in <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask

    task automatic command(input logic a, input logic b, input logic [4:0] n);
        idle_wait();
        command_number_inputs <= n;
        command_select_a <= a;
        command_select_b <= b;
        repeat (2 * TICK_CYC) @(posedge aclk);
        command_trigger_in <= 1'b1;
        see_rise();
        command_trigger_in <= 1'b0;
        @(posedge aclk);
        busy_len += int'(busy_out);
        command_number_inputs <= 5'h00;
        command_select_a <= 1'b0;
        command_select_b <= 1'b0;
        count_len();
    endtask
endmodule
`default_nettype wire

// ### tb_parallel_output_and_scene_switch.sv
// Testbench: registers, output modes and scene switching
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_output_and_scene_switch;
    import pio_pkg::*;
    localparam int TC = 10;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic step_in, transfer_request_in, command_trigger_in;
    logic command_select_a, command_select_b;
    logic [4:0] command_number_inputs;
    logic run_out, ready_out, busy_out, gate_out;
    logic [15:0] data_out;
    int failures = 0;
    int checked = 0;
    int i;

    always #10 aclk = ~aclk;

    parallel_output_and_scene_switch #(.TICK_CYC(TC)) DUT (.*);
    plc_model #(.TICK_CYC(TC)) plc (.*);

    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic hang();
        failures++;
        conclude();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 100) hang();
        check("bresp", 32'(s_axi_bresp), 32'(er));
    endtask

    task automatic rchk(input string what, input logic [7:0] a,
            input logic [31:0] exp, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 100) hang();
        check(what, s_axi_rdata, exp);
        check("rresp", 32'(s_axi_rresp), 32'(er));
    endtask

    task automatic sw(input logic a, input logic b, input logic [4:0] n,
            input logic [31:0] exp);
        plc.command(a, b, n);
        check("switch busy", 32'(plc.seen_busy), 32'(a));
        check("busy len", 32'(plc.busy_len >= 40 || !a), 32'h1);
        rchk("scene", ADDR_SCENE, exp, RESP_OKAY);
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rchk("ctrl", ADDR_CTRL, CTRL_RESET, RESP_OKAY);
        rchk("timing", ADDR_TIMING, TIMING_RESET, RESP_OKAY);
        rchk("unmapped", 8'h40, 32'h0, RESP_DECERR);
        wr(8'h40, 32'h1, RESP_DECERR);
        check("run", 32'(run_out), 32'h0);
        plc.measure();
        check("adjust busy", 32'(plc.seen_busy), 32'h0);
        $display("test reset done");

        wr(ADDR_RESULT_BASE, 32'h1234, RESP_OKAY);
        wr(ADDR_TIMING, 32'h2, RESP_OKAY);
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        plc.measure();
        check("meas len", 32'(plc.busy_len >= 2 * TC), 32'h1);
        check("run", 32'(run_out), 32'h1);
        check("ready", 32'(ready_out), 32'h1);
        check("data", 32'(data_out), 32'h1234);
        $display("test measure done");

        for (i = 0; i < 3; i++) begin
            wr(ADDR_RESULT_BASE + 8'(4 * i), 32'ha1 + 32'(i), RESP_OKAY);
        end
        wr(ADDR_CTRL, 32'h103, RESP_OKAY);
        plc.measure();
        check("held gate", 32'(gate_out), 32'h0);
        rchk("status", ADDR_STATUS, 32'h33, RESP_OKAY);
        for (i = 0; i < 4; i++) begin
            plc.request();
            check("hs data", 32'(data_out), 32'ha1 + 32'(i < 3 ? i : 2));
            check("hs gate", 32'(gate_out), 32'h1);
        end
        $display("test handshake done");

        wr(ADDR_CTRL, 32'h15, RESP_OKAY);
        for (i = 0; i < 6; i++) begin
            wr(ADDR_RESULT_BASE, 32'hb0 + 32'(i), RESP_OKAY);
            plc.measure();
            check("sync gate", 32'(gate_out), 32'(i > 2));
            if (i > 2) check("sync data", 32'(data_out), 32'hb0 + 32'(i - 3));
        end
        $display("test sync done");

        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        wr(ADDR_TIMING, 32'h0301, RESP_OKAY);
        sw(1'b1, 1'b0, 5'h1f, 32'h0001_001f);
        sw(1'b1, 1'b1, 5'h09, 32'h0002_0900);
        sw(1'b1, 1'b0, 5'h00, 32'h0003_0900);
        sw(1'b0, 1'b1, 5'h05, 32'h0003_0900);
        s_axi_wstrb <= 4'h1;
        wr(ADDR_TIMING, 32'h0000_ff07, RESP_OKAY);
        rchk("strobe", ADDR_TIMING, 32'h0000_0307, RESP_OKAY);
        $display("test switch done");
        conclude();
    end
endmodule
`default_nettype wire
